// *** logic/eiau_defines.svh ***
// Constants for the nonvolatile indirect access unit
`ifndef EIAU_DEFINES_SVH
`define EIAU_DEFINES_SVH
`define EIAU_ARRAY_DEPTH 64
`define EIAU_ADDR_W 7
`define EIAU_DATA_W 8
`define EIAU_KEY_FIRST 8'hc9
`define EIAU_KEY_SECOND 8'h3a
`define EIAU_KEY_THIRD 8'hd3
`define EIAU_ADDR_RESET 7'h00
`define EIAU_DATA_RESET 8'h00
`define EIAU_PROG_TIME_NS 100000
`define EIAU_CLK_PERIOD_NS 25
`endif

// *** logic/eiau_pkg.sv ***
// Types shared by the nonvolatile indirect access unit
package eiau_pkg;
    // Dedicated instruction codes presented by the core
    typedef enum logic [2:0] {
        EIAU_OP_NONE = 3'h0,
        EIAU_OP_READ_ADDR = 3'h1,
        EIAU_OP_WRITE_ADDR = 3'h2,
        EIAU_OP_READ_DATA = 3'h3,
        EIAU_OP_WRITE_DATA = 3'h4,
        EIAU_OP_FETCH = 3'h5,
        EIAU_OP_PROGRAM = 3'h6,
        EIAU_OP_KEY = 3'h7
    } eiau_op_t;

    // One instruction request from the core
    typedef struct packed {
        logic valid;
        eiau_op_t op;
        logic [7:0] accumulator;
    } eiau_req_t;

    // Answer towards the core
    typedef struct packed {
        logic done;
        logic [7:0] result;
    } eiau_rsp_t;

    // Key sequence progress
    typedef enum logic [1:0] {
        EIAU_KEY_IDLE = 2'b00,
        EIAU_KEY_GOT1 = 2'b01,
        EIAU_KEY_GOT2 = 2'b10,
        EIAU_KEY_OPEN = 2'b11
    } eiau_key_t;

    // Main sequencer
    typedef enum logic [1:0] {
        EIAU_ST_IDLE = 2'b00,
        EIAU_ST_PROG = 2'b01,
        EIAU_ST_DONE = 2'b10
    } eiau_state_t;
endpackage : eiau_pkg

// *** logic/eiau_key_lock.sv ***
// Unlock key sequence checker and write lock state
`timescale 1ns/1ps
`default_nettype none
`include "eiau_defines.svh"
module eiau_key_lock
    import eiau_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic key_load_i,
    input wire logic [7:0] key_byte_i,
    input wire logic other_op_i,
    input wire logic relock_i,
    output logic unlocked_o,
    output logic write_lock_state_o
);
    eiau_key_t key_reg;
    eiau_key_t key_next;
    // Expected byte for the current step
    wire logic [7:0] expect_byte = (key_reg == EIAU_KEY_IDLE) ? `EIAU_KEY_FIRST :
                                   (key_reg == EIAU_KEY_GOT1) ? `EIAU_KEY_SECOND :
                                   `EIAU_KEY_THIRD;
    wire logic hit = key_byte_i == expect_byte;

    // Next step; wrong or broken order restarts, first code may restart it
    always_comb begin
        key_next = key_reg;
        if (relock_i) begin
            key_next = EIAU_KEY_IDLE;
        end else if (key_load_i) begin
            case (key_reg)
                EIAU_KEY_IDLE: key_next = hit ? EIAU_KEY_GOT1 : EIAU_KEY_IDLE;
                EIAU_KEY_GOT1: key_next = hit ? EIAU_KEY_GOT2 :
                    (key_byte_i == `EIAU_KEY_FIRST) ? EIAU_KEY_GOT1 : EIAU_KEY_IDLE;
                EIAU_KEY_GOT2: key_next = hit ? EIAU_KEY_OPEN :
                    (key_byte_i == `EIAU_KEY_FIRST) ? EIAU_KEY_GOT1 : EIAU_KEY_IDLE;
                EIAU_KEY_OPEN: key_next = (key_byte_i == `EIAU_KEY_FIRST) ?
                    EIAU_KEY_GOT1 : EIAU_KEY_IDLE;
                default: key_next = EIAU_KEY_IDLE;
            endcase
        end else if (other_op_i && key_reg != EIAU_KEY_OPEN) begin
            key_next = EIAU_KEY_IDLE;
        end
    end

    // State register
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            key_reg <= EIAU_KEY_IDLE;
        end else begin
            key_reg <= key_next;
        end
    end

    assign unlocked_o = key_reg == EIAU_KEY_OPEN;
    // Lock bit reads one while locked
    assign write_lock_state_o = ~unlocked_o;

    relock_key_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        relock_i |=> write_lock_state_o) else $error("lock not set after write");
    open_cause_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        $rose(unlocked_o) |-> $past(key_load_i) && $past(key_byte_i) == `EIAU_KEY_THIRD)
        else $error("unlock without third code");
    unlock_seen_c: cover property (@(posedge core_clk_i) disable iff (!nrst_i) $rose(unlocked_o));
endmodule : eiau_key_lock
`default_nettype wire

// *** logic/eiau_array.sv ***
// Byte array storage for the nonvolatile block
`timescale 1ns/1ps
`default_nettype none
`include "eiau_defines.svh"
module eiau_array #(
    parameter int DEPTH = `EIAU_ARRAY_DEPTH,
    parameter int AW = 6
) (
    input wire logic core_clk_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [DEPTH];
    // Synchronous write, registered read
    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : eiau_array
`default_nettype wire

// *** logic/eiau_unit.sv ***
// Indirect access unit between core instructions and the byte array
`timescale 1ns/1ps
`default_nettype none
`include "eiau_defines.svh"
module eiau_unit
    import eiau_pkg::*;
#(
    parameter int PROG_CYCLES = (`EIAU_PROG_TIME_NS + `EIAU_CLK_PERIOD_NS - 1) /
                                `EIAU_CLK_PERIOD_NS
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire eiau_req_t req_i,
    input wire logic write_done_irq_enable_i,
    input wire logic global_irq_enable_i,
    input wire logic flag_clear_i,
    output eiau_rsp_t rsp_o,
    output logic busy_o,
    output logic write_done_flag_o,
    output logic irq_o,
    output logic write_lock_state_o
);
    // ************************************************************
    // Decode
    // ************************************************************
    localparam int CW = $clog2(PROG_CYCLES + 1);
    localparam int AW = $clog2(`EIAU_ARRAY_DEPTH);

    // Opcode match, used for every instruction strobe
    function automatic logic is_op(input eiau_req_t r, input eiau_op_t o);
        return r.valid && r.op == o;
    endfunction

    eiau_state_t state_reg;
    eiau_state_t state_next;
    logic [`EIAU_ADDR_W-1:0] array_address_reg;
    logic [`EIAU_DATA_W-1:0] array_data_reg;
    logic write_done_flag_reg;
    logic [CW-1:0] count_reg;
    logic fetch_pend_reg;
    eiau_rsp_t rsp_reg;
    logic unlocked;
    logic [7:0] array_rdata;

    // Array reached only through these instruction strobes
    // Requests are refused while programming runs
    wire logic take = state_reg == EIAU_ST_IDLE;
    wire logic do_raddr = take && is_op(req_i, EIAU_OP_READ_ADDR);
    wire logic do_waddr = take && is_op(req_i, EIAU_OP_WRITE_ADDR);
    wire logic do_rdata = take && is_op(req_i, EIAU_OP_READ_DATA);
    wire logic do_wdata = take && is_op(req_i, EIAU_OP_WRITE_DATA);
    wire logic do_fetch = take && is_op(req_i, EIAU_OP_FETCH);
    wire logic do_prog = take && is_op(req_i, EIAU_OP_PROGRAM);
    wire logic do_key = take && is_op(req_i, EIAU_OP_KEY);
    wire logic prog_go = do_prog && unlocked;
    wire logic prog_end = state_reg == EIAU_ST_PROG && count_reg == CW'(PROG_CYCLES - 1);
    wire logic commit = prog_end;
    wire logic other_op = take && req_i.valid && !do_key && !do_prog;

    // ************************************************************
    // Submodules
    // ************************************************************
    // Sequence restart and relock
    eiau_key_lock u_key (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .key_load_i(do_key),
        .key_byte_i(req_i.accumulator),
        .other_op_i(other_op),
        .relock_i(do_prog),
        .unlocked_o(unlocked),
        .write_lock_state_o(write_lock_state_o)
    );

    // Sixty-four byte store; top address bit is ignored
    eiau_array #(
        .DEPTH(`EIAU_ARRAY_DEPTH),
        .AW(AW)
    ) u_array (
        .core_clk_i(core_clk_i),
        .wr_en_i(commit),
        .addr_i(array_address_reg[AW-1:0]),
        .wdata_i(array_data_reg),
        .rdata_o(array_rdata)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Programming time elapses before the done flag rises
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            EIAU_ST_IDLE: state_next = prog_go ? EIAU_ST_PROG : EIAU_ST_IDLE;
            EIAU_ST_PROG: state_next = prog_end ? EIAU_ST_DONE : EIAU_ST_PROG;
            EIAU_ST_DONE: state_next = EIAU_ST_IDLE;
            default: state_next = EIAU_ST_IDLE;
        endcase
    end

    // State and program timer
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= EIAU_ST_IDLE;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= (state_reg == EIAU_ST_PROG) ? count_reg + CW'(1) : '0;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Address register; loaded from accumulator
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            array_address_reg <= `EIAU_ADDR_RESET;
        end else if (do_waddr) begin
            array_address_reg <= req_i.accumulator[`EIAU_ADDR_W-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            array_data_reg <= `EIAU_DATA_RESET;
        end else if (fetch_pend_reg) begin
            array_data_reg <= array_rdata;
        end else if (do_wdata) begin
            array_data_reg <= req_i.accumulator;
        end
    end

    // Fetch needs one cycle for the array read port
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fetch_pend_reg <= 1'b0;
        end else begin
            fetch_pend_reg <= do_fetch;
        end
    end

    // Done flag; set wins over clear
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            write_done_flag_reg <= 1'b0;
        end else if (prog_end) begin
            // Flag rises together with the program answer
            write_done_flag_reg <= 1'b1;
        end else if (flag_clear_i) begin
            write_done_flag_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Answers
    // ************************************************************
    // Results to accumulator; fetch returns zero as its value is undefined
    wire logic [7:0] result_mux = do_raddr ? {1'b0, array_address_reg} :
                                  do_rdata ? array_data_reg : 8'h00;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.done <= take && req_i.valid && !do_fetch && !prog_go;
            rsp_reg.result <= result_mux;
        end
    end

    // Fetch answers one cycle before the data register lands; program answers in the done state
    assign rsp_o.done = rsp_reg.done || fetch_pend_reg || state_reg == EIAU_ST_DONE;
    assign rsp_o.result = rsp_reg.result;
    assign busy_o = state_reg != EIAU_ST_IDLE;
    assign write_done_flag_o = write_done_flag_reg;
    assign irq_o = write_done_flag_reg && write_done_irq_enable_i && global_irq_enable_i;

    // ************************************************************
    // Checks
    // ************************************************************
    prog_locked_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        do_prog && !unlocked |=> state_reg == EIAU_ST_IDLE) else $error("locked write ran");
    prog_flag_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        prog_go |-> ##(PROG_CYCLES + 1) write_done_flag_o) else $error("no done flag");
    irq_gate_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        irq_o |-> write_done_flag_o && write_done_irq_enable_i && global_irq_enable_i)
        else $error("irq without enables");
    addr_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        do_raddr |=> rsp_o.result == {1'b0, $past(array_address_reg)})
        else $error("address readback wrong");
    data_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        do_wdata |=> array_data_reg == $past(req_i.accumulator)) else $error("data load lost");
    fetch_done_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        do_fetch |=> rsp_o.done ##1 array_data_reg == $past(array_rdata))
        else $error("fetch wrong");
    lock_after_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        state_reg == EIAU_ST_PROG |-> write_lock_state_o) else $error("unlocked while programming");
    prog_cov_c: cover property (@(posedge core_clk_i) disable iff (!nrst_i) prog_go);
    irq_cov_c: cover property (@(posedge core_clk_i) disable iff (!nrst_i) $rose(irq_o));
    fetch_cov_c: cover property (@(posedge core_clk_i) disable iff (!nrst_i) do_fetch);
endmodule : eiau_unit
`default_nettype wire

// *** bench/eiau_core_model.sv ***
// Behavioural core that issues the dedicated array instructions
`timescale 1ns/1ps
`default_nettype none
module eiau_core_model
    import eiau_pkg::*;
(
    input wire logic core_clk_i,
    input wire eiau_rsp_t rsp_i,
    input wire logic busy_i,
    output var eiau_req_t req_o
);
    // ****************************************
    // Instruction issue
    // ****************************************
    initial req_o = '{valid: 1'b0, op: EIAU_OP_NONE, accumulator: 8'h00};

    // One-cycle strobe; accumulator idles inverted so stale data never looks valid
    task automatic strobe(input eiau_op_t op, input logic [7:0] acc);
        @(posedge core_clk_i);
        #1;
        req_o = '{valid: 1'b1, op: op, accumulator: acc};
        @(posedge core_clk_i);
        #1;
        req_o = '{valid: 1'b0, op: EIAU_OP_NONE, accumulator: ~acc};
    endtask : strobe

    // Bounded wait, long enough for a shortened programming time
    task automatic wait_done(output logic [7:0] res, output logic ok);
        int n;
        n = 0;
        while (rsp_i.done !== 1'b1 && n < 40) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        ok = (rsp_i.done === 1'b1);
        res = rsp_i.result;
    endtask : wait_done

    task automatic issue(input eiau_op_t op, input logic [7:0] acc,
                         output logic [7:0] res, output logic ok);
        strobe(op, acc);
        wait_done(res, ok);
    endtask : issue
endmodule : eiau_core_model
`default_nettype wire

// *** bench/eiau_unit_tb.sv ***
// Self-checking bench for the indirect array access unit
`timescale 1ns/1ps
`default_nettype none
module eiau_unit_tb
    import eiau_pkg::*;
;
    localparam int PROG = 4;
    logic core_clk_i;
    logic nrst_i = 1'b0;
    logic irq_en = 1'b0;
    logic global_irq_enable = 1'b0;
    logic clr = 1'b0;
    eiau_req_t req;
    eiau_rsp_t rsp;
    logic busy, flag, irq, lock, ok;
    logic [7:0] r;
    int err_total = 0;
    int n_tests = 0;

    eiau_unit #(.PROG_CYCLES(PROG)) dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .req_i(req), .write_done_irq_enable_i(irq_en), .global_irq_enable_i(global_irq_enable),
        .flag_clear_i(clr), .rsp_o(rsp), .busy_o(busy), .write_done_flag_o(flag),
        .irq_o(irq), .write_lock_state_o(lock));
    eiau_core_model core (.core_clk_i(core_clk_i), .rsp_i(rsp), .busy_i(busy), .req_o(req));

    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic run(input eiau_op_t op, input logic [7:0] acc);
        core.issue(op, acc, r, ok);
        check("answer", {7'h00, ok}, 8'h01);
    endtask : run

    task automatic unlock();
        run(EIAU_OP_KEY, 8'hc9);
        run(EIAU_OP_KEY, 8'h3a);
        run(EIAU_OP_KEY, 8'hd3);
    endtask : unlock

    task automatic write_cell(input logic [7:0] a, input logic [7:0] d);
        unlock();
        run(EIAU_OP_WRITE_ADDR, a);
        run(EIAU_OP_WRITE_DATA, d);
        run(EIAU_OP_PROGRAM, 8'h00);
    endtask : write_cell

    // Data register lands one cycle after the fetch is taken
    task automatic read_cell(input logic [7:0] a, input logic [7:0] exp);
        run(EIAU_OP_WRITE_ADDR, a);
        run(EIAU_OP_FETCH, 8'h00);
        repeat (2) @(posedge core_clk_i);
        run(EIAU_OP_READ_DATA, 8'h00);
        check("cell", r, exp);
    endtask : read_cell

    task automatic pulse_clear();
        @(posedge core_clk_i);
        #1 clr = 1'b1;
        @(posedge core_clk_i);
        #1 clr = 1'b0;
    endtask : pulse_clear

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check("lock", {7'h00, lock}, 8'h01);
        check("flag", {7'h00, flag}, 8'h00);
        run(EIAU_OP_READ_ADDR, 8'hff);
        check("addr", r, 8'h00);
        run(EIAU_OP_READ_DATA, 8'hff);
        check("data", r, 8'h00);
    endtask : t_reset

    task automatic t_regs();
        run(EIAU_OP_WRITE_ADDR, 8'h45);
        run(EIAU_OP_READ_ADDR, 8'h00);
        check("addr", r, 8'h45);
        run(EIAU_OP_WRITE_DATA, 8'ha5);
        run(EIAU_OP_READ_DATA, 8'h00);
        check("data", r, 8'ha5);
    endtask : t_regs

    // Full write with busy, refusal, flag, interrupt gating and relock
    task automatic t_program();
        irq_en = 1'b1;
        global_irq_enable = 1'b1;
        run(EIAU_OP_KEY, 8'hc9);
        run(EIAU_OP_KEY, 8'h3a);
        check("lock", {7'h00, lock}, 8'h01);
        run(EIAU_OP_KEY, 8'hd3);
        check("lock", {7'h00, lock}, 8'h00);
        run(EIAU_OP_WRITE_ADDR, 8'h03);
        run(EIAU_OP_WRITE_DATA, 8'h11);
        check("lock", {7'h00, lock}, 8'h00);
        core.strobe(EIAU_OP_PROGRAM, 8'h00);
        @(posedge core_clk_i);
        #1;
        check("busy", {7'h00, busy}, 8'h01);
        check("lock", {7'h00, lock}, 8'h01);
        core.strobe(EIAU_OP_WRITE_ADDR, 8'h20);
        core.wait_done(r, ok);
        check("done", {7'h00, ok}, 8'h01);
        check("flag", {7'h00, flag}, 8'h01);
        check("irq", {7'h00, irq}, 8'h01);
        irq_en = 1'b0;
        #1 check("irq", {7'h00, irq}, 8'h00);
        irq_en = 1'b1;
        global_irq_enable = 1'b0;
        #1 check("irq", {7'h00, irq}, 8'h00);
        global_irq_enable = 1'b1;
        pulse_clear();
        check("flag", {7'h00, flag}, 8'h00);
        run(EIAU_OP_READ_ADDR, 8'h00);
        check("addr", r, 8'h03);
        read_cell(8'h03, 8'h11);
        write_cell(8'h3f, 8'h22);
        read_cell(8'h3f, 8'h22);
        read_cell(8'h03, 8'h11);
    endtask : t_program

    task automatic t_locked();
        pulse_clear();
        run(EIAU_OP_WRITE_DATA, 8'h5a);
        run(EIAU_OP_PROGRAM, 8'h00);
        check("flag", {7'h00, flag}, 8'h00);
        read_cell(8'h03, 8'h11);
    endtask : t_locked

    task automatic t_badkey();
        run(EIAU_OP_KEY, 8'hc9);
        run(EIAU_OP_KEY, 8'h3a);
        run(EIAU_OP_KEY, 8'h00);
        run(EIAU_OP_KEY, 8'hd3);
        check("lock", {7'h00, lock}, 8'h01);
        run(EIAU_OP_KEY, 8'hc9);
        run(EIAU_OP_WRITE_DATA, 8'h77);
        run(EIAU_OP_KEY, 8'h3a);
        run(EIAU_OP_KEY, 8'hd3);
        check("lock", {7'h00, lock}, 8'h01);
        run(EIAU_OP_KEY, 8'hc9);
        unlock();
        check("lock", {7'h00, lock}, 8'h00);
        run(EIAU_OP_PROGRAM, 8'h00);
        read_cell(8'h03, 8'h77);
    endtask : t_badkey

    task automatic end_sim();
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // Watchdog far beyond the roughly 130 cycles the scenarios need
    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_total++;
        end_sim();
    end

    // one normal-speed clock throughout, hang cut by the watchdog
    initial begin
        repeat (3) @(posedge core_clk_i);
        #1 nrst_i = 1'b1;
        t_reset();
        t_regs();
        t_program();
        t_locked();
        t_badkey();
        end_sim();
    end
endmodule : eiau_unit_tb
`default_nettype wire
